// ===== hdl/spi_port_defs.vh
// Register map, field positions, reset values and rate table of the serial port
`ifndef SPI_PORT_DEFS_VH
`define SPI_PORT_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_CTRL       3'h0
`define ADDR_STATUS     3'h1
`define ADDR_DATA       3'h2
`define ADDR_PINS       3'h3

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTRL_IRQ_EN     7
`define CTRL_ENABLE     6
`define CTRL_LSB_FIRST  5
`define CTRL_MASTER     4
`define CTRL_CPOL       3
`define CTRL_CPHA       2
`define CTRL_RATE_HI    1
`define CTRL_RATE_LO    0

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define STAT_DONE       7
`define STAT_COLL       6
`define STAT_DOUBLE     0

// ----------------------------------------------------------------
// Pin configuration register fields
// ----------------------------------------------------------------
`define PINS_MOSI_DIR   0
`define PINS_MISO_DIR   1
`define PINS_SCK_DIR    2
`define PINS_SS_DIR     3
`define PINS_SS_LEVEL   4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CTRL_RESET      8'h00
`define PINS_RESET      5'h10
`define PIN_SYNC_RESET  4'h8

// ----------------------------------------------------------------
// Half periods of the master clock, in system clocks
// ----------------------------------------------------------------
`define HALF_DIV2       7'h01
`define HALF_DIV4       7'h02
`define HALF_DIV8       7'h04
`define HALF_DIV16      7'h08
`define HALF_DIV32      7'h10
`define HALF_DIV64      7'h20
`define HALF_DIV128     7'h40

// ----------------------------------------------------------------
// Byte framing counts
// ----------------------------------------------------------------
`define EDGE_LAST       4'hF
`define BIT_LAST        3'h7

`endif

// ===== hdl/sck_divider.v
// Half-period tick generator for the master serial clock
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_defs.vh"

module sck_divider (
  input  wire       clk,
  input  wire       reset,
  input  wire       run,
  input  wire       double_speed,
  input  wire [1:0] rate,
  output reg        tick
);

  reg [6:0] count;
  reg [6:0] half;

  // ----------------------------------------------------------------
  // Rate table
  // ----------------------------------------------------------------
  always @* begin
    case ({double_speed, rate})
      3'b000:  half = `HALF_DIV4;
      3'b001:  half = `HALF_DIV16;
      3'b010:  half = `HALF_DIV64;
      3'b011:  half = `HALF_DIV128;
      3'b100:  half = `HALF_DIV2;
      3'b101:  half = `HALF_DIV8;
      3'b110:  half = `HALF_DIV32;
      default: half = `HALF_DIV64;
    endcase
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Restarts from zero each byte so the first edge is a full half period late
  always @(posedge clk) begin
    if (reset || !run) begin
      count <= 7'h00;
      tick  <= 1'b0;
    end else if (count == half - 7'h01) begin
      count <= 7'h00;
      tick  <= 1'b1;
    end else begin
      count <= count + 7'h01;
      tick  <= 1'b0;
    end
  end

endmodule // sck_divider
`default_nettype wire

// ===== hdl/serial_peripheral_port.v
// Serial peripheral port: register slave, pin control and shift engine
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_defs.vh"

// How it works
// - Master data write shifts out eight bits
// - Master stops clock, sets done flag
// - Done flag with enable raises interrupt
// - Select line driven only by software
// - MOSI master-to-slave, MISO back, master clocks
// - Unselected slave idles, MISO released
// - Slave loads data, shifts only when selected
// - Slave sets done flag per byte
// - Slave accepts new byte before read
// - Last received byte kept for reading
// - Single transmit buffer, double receive buffer
// - Unread received byte is overwritten
// - External clock phases exceed two clocks
// - Enabled port overrides pin directions
// - Bit order, seven rates, double speed
// - Master rate divides system clock, 2-128
// - Polarity sets idle level, phase sample edge
// - Ack or status-then-data clears done flag
// - Select input low as master forces slave
module serial_peripheral_port (
  input  wire       MCLK,
  input  wire       RESET,
  input  wire [2:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  output reg  [7:0] RDATA,
  output reg        IRQ,
  input  wire       IRQ_ACK,
  input  wire       SCK_IN,
  output reg        SCK_OUT,
  output reg        SCK_OE,
  input  wire       MOSI_IN,
  output reg        MOSI_OUT,
  output reg        MOSI_OE,
  input  wire       MISO_IN,
  output reg        MISO_OUT,
  output reg        MISO_OE,
  input  wire       SS_N_IN,
  output reg        SS_N_OUT,
  output reg        SS_N_OE
);

  localparam [1:0] ST_IDLE  = 2'b01;
  localparam [1:0] ST_SHIFT = 2'b10;
  localparam [3:0] PIN_IDLE = `PIN_SYNC_RESET;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire [3:0] pin_raw;
  wire [3:0] pin_sync;

  assign pin_raw = {SS_N_IN, MISO_IN, MOSI_IN, SCK_IN};

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_sync
      reg meta;
      reg held;
      always @(posedge MCLK) begin
        if (RESET) begin
          meta <= PIN_IDLE[g];
          held <= PIN_IDLE[g];
        end else begin
          meta <= pin_raw[g];
          held <= meta;
        end
      end
      assign pin_sync[g] = held;
    end
  endgenerate

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg  [7:0] ctrl;
  reg        double_speed;
  reg  [4:0] pins;
  reg        done_flag;
  reg        coll_flag;
  reg        clear_armed;
  reg  [7:0] sr;
  reg  [7:0] rx_buf;
  reg        out_bit;
  reg        sck_level;
  reg        sck_prev;
  reg  [1:0] mstate;
  reg  [3:0] edge_cnt;
  reg  [2:0] bit_cnt;
  reg  [7:0] next_rdata;

  wire       tick;
  wire       enable    = ctrl[`CTRL_ENABLE];
  wire       master    = ctrl[`CTRL_MASTER];
  wire       cpol      = ctrl[`CTRL_CPOL];
  wire       cpha      = ctrl[`CTRL_CPHA];
  wire       lsb_first = ctrl[`CTRL_LSB_FIRST];
  wire       ss_low    = ~pin_sync[3];
  wire       sck_s     = pin_sync[0];
  wire       shifting  = mstate[1];

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire wr_ctrl     = WR & (ADDR == `ADDR_CTRL);
  wire wr_stat     = WR & (ADDR == `ADDR_STATUS);
  wire wr_data     = WR & (ADDR == `ADDR_DATA);
  wire wr_pins     = WR & (ADDR == `ADDR_PINS);
  wire rd_stat     = RD & (ADDR == `ADDR_STATUS);
  wire data_access = (WR | RD) & (ADDR == `ADDR_DATA);

  // ----------------------------------------------------------------
  // Edge classification
  // ----------------------------------------------------------------
  wire slave_on = enable & ~master & ss_low;
  wire sck_chg  = slave_on & (sck_s ^ sck_prev);
  // Leading edge leaves the idle level, trailing edge returns to it
  wire lead     = master ? (shifting & tick & ~edge_cnt[0])
                         : (sck_chg & (sck_s ^ cpol));
  wire trail    = master ? (shifting & tick & edge_cnt[0])
                         : (sck_chg & ~(sck_s ^ cpol));
  wire sample   = cpha ? trail : lead;
  wire setup    = cpha ? lead : trail;
  // Master listens on MISO, slave on MOSI
  wire in_bit   = master ? pin_sync[2] : pin_sync[1];
  wire head     = lsb_first ? sr[0] : sr[7];
  wire [7:0] shifted = lsb_first ? {in_bit, sr[7:1]} : {sr[6:0], in_bit};
  wire whead    = lsb_first ? WDATA[0] : WDATA[7];

  wire m_finish   = shifting & tick & (edge_cnt == `EDGE_LAST);
  wire s_finish   = ~master & sample & (bit_cnt == `BIT_LAST);
  wire byte_cpl   = m_finish | s_finish;
  wire mode_fault = enable & master & ~pins[`PINS_SS_DIR] & ss_low;
  wire mid_byte   = shifting | (bit_cnt != 3'h0);
  wire collide    = wr_data & mid_byte;
  wire start      = wr_data & ~mid_byte & enable & master & ~mode_fault;
  wire flag_clear = (clear_armed & data_access) | IRQ_ACK;

  // ----------------------------------------------------------------
  // Master clock divider
  // ----------------------------------------------------------------
  sck_divider i_sck_divider (
    .clk          (MCLK),
    .reset        (RESET),
    .run          (shifting),
    .double_speed (double_speed),
    .rate         ({ctrl[`CTRL_RATE_HI], ctrl[`CTRL_RATE_LO]}),
    .tick         (tick)
  );

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always @(posedge MCLK) begin
    if (RESET) begin
      ctrl         <= `CTRL_RESET;
      double_speed <= 1'b0;
      pins         <= `PINS_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= WDATA;
      end
      // Hardware demotion beats a same-cycle software write
      if (mode_fault) begin
        ctrl[`CTRL_MASTER] <= 1'b0;
      end
      if (wr_stat) begin
        double_speed <= WDATA[`STAT_DOUBLE];
      end
      if (wr_pins) begin
        pins <= WDATA[4:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  // A set in the clearing cycle wins, so no completion is lost
  always @(posedge MCLK) begin
    if (RESET) begin
      done_flag   <= 1'b0;
      coll_flag   <= 1'b0;
      clear_armed <= 1'b0;
    end else begin
      if (byte_cpl || mode_fault) begin
        done_flag <= 1'b1;
      end else if (flag_clear) begin
        done_flag <= 1'b0;
      end
      if (collide) begin
        coll_flag <= 1'b1;
      end else if (clear_armed && data_access) begin
        coll_flag <= 1'b0;
      end
      if (rd_stat && (done_flag || coll_flag)) begin
        clear_armed <= 1'b1;
      end else if (data_access || IRQ_ACK) begin
        clear_armed <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------
  always @(posedge MCLK) begin
    if (RESET) begin
      mstate    <= ST_IDLE;
      edge_cnt  <= 4'h0;
      bit_cnt   <= 3'h0;
      sr        <= 8'h00;
      rx_buf    <= 8'h00;
      out_bit   <= 1'b0;
      sck_level <= 1'b0;
      sck_prev  <= 1'b0;
    end else begin
      sck_prev <= sck_s;
      // Transmit and receive share one register; only the receive side is buffered
      if (wr_data && !mid_byte) begin
        sr <= WDATA;
      end else if (sample) begin
        sr <= shifted;
      end
      if (wr_data && !mid_byte && !cpha) begin
        out_bit <= whead;
      end else if (setup) begin
        out_bit <= head;
      end else if (!master && bit_cnt == 3'h0 && !cpha && !sample) begin
        out_bit <= head;
      end
      // Overwrites an unread byte; software must keep up
      if (byte_cpl) begin
        rx_buf <= sample ? shifted : sr;
      end
      // Deselect drops any partial byte and keeps the slave framed
      if (master || !slave_on) begin
        bit_cnt <= 3'h0;
      end else if (sample) begin
        bit_cnt <= bit_cnt + 3'h1;
      end
      case (mstate)
        ST_IDLE: begin
          sck_level <= cpol;
          edge_cnt  <= 4'h0;
          if (start) begin
            mstate <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (mode_fault || !enable || !master) begin
            mstate <= ST_IDLE;
          end else if (tick) begin
            sck_level <= ~sck_level;
            edge_cnt  <= edge_cnt + 4'h1;
            if (m_finish) begin
              mstate <= ST_IDLE;
            end
          end
        end
        default: begin
          mstate <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always @* begin
    next_rdata = 8'h00;
    if (RD) begin
      case (ADDR)
        `ADDR_CTRL:   next_rdata = ctrl;
        `ADDR_STATUS: next_rdata = {done_flag, coll_flag, 5'h00, double_speed};
        `ADDR_DATA:   next_rdata = rx_buf;
        `ADDR_PINS:   next_rdata = {3'h0, pins};
        default:      next_rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  // Data and clock take the same one-cycle delay so their relation holds
  always @(posedge MCLK) begin
    if (RESET) begin
      RDATA    <= 8'h00;
      IRQ      <= 1'b0;
      SCK_OUT  <= 1'b0;
      SCK_OE   <= 1'b0;
      MOSI_OUT <= 1'b0;
      MOSI_OE  <= 1'b0;
      MISO_OUT <= 1'b0;
      MISO_OE  <= 1'b0;
      SS_N_OUT <= 1'b1;
      SS_N_OE  <= 1'b0;
    end else begin
      RDATA    <= next_rdata;
      IRQ      <= ctrl[`CTRL_IRQ_EN] & done_flag;
      SCK_OUT  <= sck_level;
      MOSI_OUT <= out_bit;
      MISO_OUT <= out_bit;
      SS_N_OUT <= pins[`PINS_SS_LEVEL];
      SCK_OE   <= enable & master & pins[`PINS_SCK_DIR];
      MOSI_OE  <= enable & master & pins[`PINS_MOSI_DIR];
      SS_N_OE  <= enable & master & pins[`PINS_SS_DIR];
      MISO_OE  <= enable & ~master & ss_low & pins[`PINS_MISO_DIR];
    end
  end

endmodule // serial_peripheral_port
`default_nettype wire

// ===== sim/spi_port_monitor.sv
// Concurrent checks on the serial port's bus and pin outputs
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_defs.vh"
module spi_port_monitor (
  input wire logic       MCLK,
  input wire logic       RESET,
  input wire logic [2:0] ADDR,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       IRQ,
  input wire logic       IRQ_ACK,
  input wire logic       SCK_OUT,
  input wire logic       SCK_OE,
  input wire logic       MOSI_OE,
  input wire logic       MISO_OE,
  input wire logic       SS_N_IN,
  input wire logic       SS_N_OUT,
  input wire logic       SS_N_OE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  // One cycle of margin over the two synchroniser flops and the output flop
  sequence slave_idle;
    SS_N_IN [*5];
  endsequence
  sequence ack_when_quiet;
    IRQ_ACK && SS_N_IN && $stable(SCK_OUT);
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_rdata_no_read: assert property (!RD |=> RDATA == 8'h00)
    else $error("read data present without a read");
  a_unmapped_zero: assert property (RD && ADDR[2] |=> RDATA == 8'h00)
    else $error("unmapped address read not zero");
  a_status_reserved: assert property (RD && ADDR == `ADDR_STATUS |=> RDATA[5:1] == 5'h00)
    else $error("reserved status bits not zero");
  a_master_miso_input: assert property (SCK_OE |-> !MISO_OE)
    else $error("miso driven while serial clock driven");
  a_slave_only_miso: assert property (MISO_OE |-> !MOSI_OE && !SCK_OE && !SS_N_OE)
    else $error("slave drives a pin other than miso");
  a_unselected_quiet: assert property (slave_idle |-> !MISO_OE)
    else $error("miso driven while unselected");
  a_ack_drops_irq: assert property (ack_when_quiet |=> ##1 !IRQ)
    else $error("interrupt still up after acknowledge");
  a_ss_by_software: assert property ($changed(SS_N_OUT) |->
    $past(WR && ADDR == `ADDR_PINS) || $past(WR && ADDR == `ADDR_PINS, 2))
    else $error("select output moved without a pins write");
endmodule // spi_port_monitor
bind serial_peripheral_port spi_port_monitor i_spi_port_monitor (.MCLK(MCLK), .RESET(RESET), .ADDR(ADDR),
  .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .IRQ_ACK(IRQ_ACK), .SCK_OUT(SCK_OUT), .SCK_OE(SCK_OE),
  .MOSI_OE(MOSI_OE), .MISO_OE(MISO_OE), .SS_N_IN(SS_N_IN), .SS_N_OUT(SS_N_OUT), .SS_N_OE(SS_N_OE));
`default_nettype wire

// ===== sim/spi_peer_model.sv
// Mode 0 serial peripheral standing on the far side of the port
`timescale 1ns/1ps
`default_nettype none
module spi_peer_model (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  input  wire logic [7:0] tx_byte,
  output var  logic       miso,
  output var  logic [7:0] rx_byte
);
  logic [7:0] shift;
  logic       last;
  initial begin
    shift = 8'h00;
    rx_byte = 8'h00;
    last = 1'b0;
  end
  always @(negedge ss_n) shift = tx_byte;
  always @(posedge sck) if (!ss_n) rx_byte = {rx_byte[6:0], mosi};
  always @(negedge sck) if (!ss_n) shift = {shift[6:0], 1'b0};
  // Released line shows the inverse of the last bit, never a stale copy
  always @* begin
    if (!ss_n) begin
      miso = shift[7];
      last = shift[7];
    end else miso = ~last;
  end
endmodule // spi_peer_model
`default_nettype wire

// ===== sim/tb_serial_peripheral_port.sv
// Self-checking testbench of the serial peripheral port
`timescale 1ns/1ps
`default_nettype none
module tb_serial_peripheral_port;
  logic       MCLK = 0, RESET = 1, WR = 0, RD = 0, IRQ_ACK = 0, tb_sck = 0, tb_mosi = 0, tb_ss_n = 1;
  logic [2:0] ADDR = 3'h0;
  logic [7:0] WDATA = 8'h00, peer_tx = 8'h00, RDATA, peer_rx, v;
  logic       IRQ, SCK_OUT, SCK_OE, MOSI_OUT, MOSI_OE, MISO_OUT, MISO_OE, SS_N_OUT, SS_N_OE, peer_miso;
  int         err_count = 0, checked = 0, cycles = 0, n, r;
  localparam logic [7:0] HALF [8] = '{8'h02, 8'h08, 8'h20, 8'h40, 8'h01, 8'h04, 8'h10, 8'h20};
  wire        sck_w = SCK_OE ? SCK_OUT : tb_sck;
  wire        mosi_w = MOSI_OE ? MOSI_OUT : tb_mosi;
  wire        miso_w = MISO_OE ? MISO_OUT : peer_miso;
  wire        ss_w = SS_N_OE ? SS_N_OUT : tb_ss_n;
  wire        peer_ss = SS_N_OE ? SS_N_OUT : 1'b1;
  serial_peripheral_port i_serial_peripheral_port (.MCLK(MCLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .IRQ_ACK(IRQ_ACK), .SCK_IN(sck_w), .SCK_OUT(SCK_OUT),
    .SCK_OE(SCK_OE), .MOSI_IN(mosi_w), .MOSI_OUT(MOSI_OUT), .MOSI_OE(MOSI_OE), .MISO_IN(miso_w),
    .MISO_OUT(MISO_OUT), .MISO_OE(MISO_OE), .SS_N_IN(ss_w), .SS_N_OUT(SS_N_OUT), .SS_N_OE(SS_N_OE));
  spi_peer_model i_spi_peer_model (.sck(sck_w), .mosi(mosi_w), .ss_n(peer_ss), .tx_byte(peer_tx),
    .miso(peer_miso), .rx_byte(peer_rx));
  always #12.5 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      complete_run();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task complete_run;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge MCLK); ADDR <= a; WDATA <= d; WR <= 1'b1;
    @(posedge MCLK); WR <= 1'b0;
  endtask
  task rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge MCLK); ADDR <= a; RD <= 1'b1;
    @(posedge MCLK); RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task wait_done;
    int i;
    v = 8'h00;
    for (i = 0; i < 600 && v[7] !== 1'b1; i++) rd(3'h1, v);
    if (v[7] !== 1'b1) chk(v, 8'h80, "done flag");
  endtask
  task wait_sck(output int k);
    logic l;
    l = SCK_OUT;
    k = 0;
    do begin
      @(posedge MCLK);
      #1 k++;
    end while (SCK_OUT === l && k < 300);
  endtask
  // Mode 0 master in the bench, 200 ns link clock, each phase four system clocks
  task slave_byte(input logic [7:0] mo, output logic [7:0] mi);
    int i;
    for (i = 7; i >= 0; i--) begin
      @(posedge MCLK); tb_mosi <= mo[i]; tb_sck <= 1'b0;
      repeat (4) @(posedge MCLK);
      tb_sck <= 1'b1;
      // The port's output lags the setup edge by four clocks, so read it once settled
      @(posedge MCLK);
      #1 mi[i] = miso_w;
      repeat (2) @(posedge MCLK);
    end
    @(posedge MCLK); tb_sck <= 1'b0;
    repeat (6) @(posedge MCLK);
  endtask
  task master_xfer(input logic [7:0] ctrl, d, ptx, exp_peer, exp_rd);
    peer_tx = ptx;
    wr(3'h3, 8'h0D);
    wr(3'h0, ctrl);
    wr(3'h2, d);
    wait_done;
    chk({7'h00, SCK_OUT}, 8'h00, "sck idle");
    chk({7'h00, IRQ}, 8'h01, "irq");
    chk(peer_rx, exp_peer, "peer rx");
    rd(3'h2, v); chk(v, exp_rd, "rx byte");
    rd(3'h1, v); chk(v, 8'h00, "status cleared");
    wr(3'h3, 8'h1D);
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge MCLK);
    RESET <= 1'b0;
    rd(3'h0, v); chk(v, 8'h00, "ctrl reset");
    rd(3'h1, v); chk(v, 8'h00, "status reset");
    rd(3'h3, v); chk(v, 8'h10, "pins reset");
    rd(3'h5, v); chk(v, 8'h00, "unmapped read");
    $display("test reset done");
    master_xfer(8'hD1, 8'hA5, 8'h3C, 8'hA5, 8'h3C);
    master_xfer(8'hF1, 8'h01, 8'h0F, 8'h80, 8'hF0);
    wr(3'h3, 8'h0D);
    wr(3'h2, 8'h5A);
    wr(3'h2, 8'hFF);
    wait_done;
    chk(peer_rx, 8'h5A, "peer rx after refused write");
    rd(3'h1, v); chk(v, 8'hC0, "collision status");
    rd(3'h2, v); chk(v, 8'hF0, "rx after collision");
    rd(3'h1, v); chk(v, 8'h00, "status cleared");
    wr(3'h3, 8'h1D);
    $display("test master done");
    for (r = 0; r < 8; r++) begin
      wr(3'h1, {7'h00, r[2]});
      wr(3'h0, 8'hD0 | r[7:0]);
      wr(3'h2, 8'h81);
      wait_sck(n);
      wait_sck(n);
      chk(n[7:0], HALF[r], "sck half period");
      wait_done;
      @(posedge MCLK); IRQ_ACK <= 1'b1;
      @(posedge MCLK); IRQ_ACK <= 1'b0;
      rd(3'h1, v); chk(v, {7'h00, r[2]}, "status after ack");
      chk({7'h00, IRQ}, 8'h00, "irq after ack");
    end
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h58);
    repeat (3) @(posedge MCLK);
    chk({7'h00, SCK_OUT}, 8'h01, "sck idle high");
    $display("test rates done");
    wr(3'h3, 8'h17);
    wr(3'h0, 8'h50);
    @(posedge MCLK); tb_ss_n <= 1'b0;
    repeat (6) @(posedge MCLK);
    rd(3'h0, v); chk(v, 8'h40, "demoted ctrl");
    rd(3'h1, v); chk(v, 8'h80, "demoted status");
    chk({6'h00, SCK_OE, MOSI_OE}, 8'h00, "slave pin override");
    rd(3'h2, v);
    @(posedge MCLK); tb_ss_n <= 1'b1;
    $display("test demotion done");
    wr(3'h0, 8'h40);
    wr(3'h3, 8'h12);
    wr(3'h2, 8'hC3);
    slave_byte(8'hFF, v);
    chk({7'h00, MISO_OE}, 8'h00, "miso released");
    @(posedge MCLK); tb_ss_n <= 1'b0;
    repeat (8) @(posedge MCLK);
    slave_byte(8'h96, v);
    chk(v, 8'hC3, "slave tx");
    rd(3'h1, v); chk(v, 8'h80, "slave done");
    wr(3'h2, 8'h0F);
    slave_byte(8'h69, v);
    chk(v, 8'h0F, "slave second tx");
    rd(3'h2, v); chk(v, 8'h69, "slave rx");
    @(posedge MCLK); tb_ss_n <= 1'b1;
    repeat (6) @(posedge MCLK);
    chk({7'h00, MISO_OE}, 8'h00, "miso released after frame");
    $display("test slave done");
    complete_run();
  end
endmodule // tb_serial_peripheral_port
`default_nettype wire
